// ### design/operand_addr_calc.sv
// Addressing constants package and the 8-bit address arithmetic unit
package addr_mode_pkg;
    localparam int ADDR_W = 8;
    localparam logic [1:0] LEN_NONE  = 2'h0;
    localparam logic [1:0] LEN_TWO   = 2'h2;
    localparam logic [1:0] LEN_THREE = 2'h3;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [7:0] ONE_BYTE  = 8'h01;

    typedef enum logic [2:0] {
        MODE_DST_DIR     = 3'h0,
        MODE_DST_IDX     = 3'h1,
        MODE_DST_DIR_IMM = 3'h2,
        MODE_DST_IDX_IMM = 3'h3,
        MODE_MEM_MOV     = 3'h4,
        MODE_SRC_IND     = 3'h5,
        MODE_DST_IND     = 3'h6,
        MODE_ILLEGAL     = 3'h7
    } mode_t;
endpackage : addr_mode_pkg

`timescale 1ns/1ps
module operand_addr_calc #(
    parameter int WIDTH = addr_mode_pkg::ADDR_W
) (
    input  wire logic [WIDTH-1:0] base_in,
    input  wire logic [WIDTH-1:0] idx_in,
    input  wire logic             use_idx_in,
    input  wire logic [WIDTH-1:0] ptr_in,
    output logic      [WIDTH-1:0] sum_out,
    output logic      [WIDTH-1:0] inc_out
);
    if (WIDTH != 8)
    begin : g_bad_width
        $error("operand_addr_calc serves 8-bit addresses only");
    end

    // Carry out of the top bit is dropped on purpose
    assign sum_out = use_idx_in ? WIDTH'(base_in + idx_in) : base_in;
    assign inc_out = WIDTH'(ptr_in + WIDTH'(1));
endmodule : operand_addr_calc

// ### design/cpu_operand_addressing.sv
// Operand addressing sequencer: effective address, memory and register space access
`timescale 1ns/1ps
module cpu_operand_addressing (
    input  wire logic                 clk_in,
    input  wire logic                 rst_n_in,
    input  wire logic                 start_in,
    input  wire addr_mode_pkg::mode_t mode_in,
    input  wire logic                 arith_in,
    input  wire logic                 src_x_in,
    input  wire logic                 reg_space_in,
    input  wire logic [7:0]           opnd1_in,
    input  wire logic [7:0]           opnd2_in,
    input  wire logic [7:0]           acc_in,
    input  wire logic [7:0]           idx_in,
    input  wire logic [7:0]           alu_result_in,
    input  wire logic [7:0]           rdata_in,
    output logic      [1:0]           len_out,
    output logic                      busy_out,
    output logic                      done_out,
    output logic      [7:0]           addr_out,
    output logic      [7:0]           wdata_out,
    output logic                      ram_rd_out,
    output logic                      ram_wr_out,
    output logic                      reg_rd_out,
    output logic                      reg_wr_out,
    output logic      [7:0]           alu_a_out,
    output logic      [7:0]           alu_b_out,
    output logic                      acc_load_out,
    output logic      [7:0]           acc_data_out
);
    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_CAP1 = 3'h1,
        S_CAP2 = 3'h2,
        S_WR   = 3'h3,
        S_INC  = 3'h4
    } state_t;

    state_t               state;
    state_t               next_state;
    addr_mode_pkg::mode_t mode_q;
    addr_mode_pkg::mode_t next_mode_q;
    logic       arith_q, next_arith_q;
    logic       space_q, next_space_q;
    logic [7:0] src_q, next_src_q;
    logic [7:0] ea_q, next_ea_q;
    logic [7:0] op1_q, next_op1_q;
    logic [7:0] ptr_q, next_ptr_q;
    logic [1:0] next_len;
    logic       next_busy, next_done;
    logic [7:0] next_addr, next_wdata;
    logic       next_ram_rd, next_ram_wr, next_reg_rd, next_reg_wr;
    logic [7:0] next_alu_a, next_alu_b;
    logic       next_acc_load;
    logic [7:0] next_acc_data;
    logic       bus_rd, bus_wr, bus_reg;
    logic       use_idx;
    logic [7:0] ea_sum;
    logic [7:0] ptr_inc;

    assign use_idx = (mode_in == addr_mode_pkg::MODE_DST_IDX)
                  || (mode_in == addr_mode_pkg::MODE_DST_IDX_IMM);

    operand_addr_calc #(
        .WIDTH (addr_mode_pkg::ADDR_W)
    ) u_calc (
        .base_in    (opnd1_in),
        .idx_in     (idx_in),
        .use_idx_in (use_idx),
        .ptr_in     (ptr_q),
        .sum_out    (ea_sum),
        .inc_out    (ptr_inc)
    );

    always_comb
    begin
        next_state    = state;
        next_mode_q   = mode_q;
        next_arith_q  = arith_q;
        next_space_q  = space_q;
        next_src_q    = src_q;
        next_ea_q     = ea_q;
        next_op1_q    = op1_q;
        next_ptr_q    = ptr_q;
        next_len      = len_out;
        next_busy     = busy_out;
        next_done     = 1'b0;
        next_addr     = addr_out;
        next_wdata    = wdata_out;
        next_alu_a    = alu_a_out;
        next_alu_b    = alu_b_out;
        next_acc_load = 1'b0;
        next_acc_data = acc_data_out;
        bus_rd        = 1'b0;
        bus_wr        = 1'b0;
        bus_reg       = space_q;
        unique case (state)
            S_IDLE:
            begin
                if (start_in)
                begin
                    next_mode_q  = mode_in;
                    next_arith_q = arith_in;
                    next_op1_q   = opnd1_in;
                    next_ea_q    = ea_sum;
                    // Space follows the opcode bit, never the operand value; move and indirect modes below force RAM
                    next_space_q = reg_space_in;
                    bus_reg      = reg_space_in;
                    next_busy    = 1'b1;
                    if (mode_in == addr_mode_pkg::MODE_DST_DIR && src_x_in)
                        next_src_q = idx_in;
                    else if (mode_in == addr_mode_pkg::MODE_DST_DIR_IMM
                          || mode_in == addr_mode_pkg::MODE_DST_IDX_IMM)
                        next_src_q = opnd2_in;
                    else
                        next_src_q = acc_in;
                    unique case (mode_in)
                        addr_mode_pkg::MODE_DST_DIR,
                        addr_mode_pkg::MODE_DST_IDX:
                            next_len = addr_mode_pkg::LEN_TWO;
                        addr_mode_pkg::MODE_DST_DIR_IMM,
                        addr_mode_pkg::MODE_DST_IDX_IMM:
                            next_len = addr_mode_pkg::LEN_THREE;
                        addr_mode_pkg::MODE_MEM_MOV:
                            next_len = addr_mode_pkg::LEN_THREE;
                        addr_mode_pkg::MODE_SRC_IND,
                        addr_mode_pkg::MODE_DST_IND:
                            next_len = addr_mode_pkg::LEN_TWO;
                        default:
                            next_len = addr_mode_pkg::LEN_NONE;
                    endcase
                    if (mode_in <= addr_mode_pkg::MODE_DST_IDX_IMM)
                    begin
                        next_addr = ea_sum;
                        if (arith_in)
                        begin
                            // Destination is also the second source
                            bus_rd     = 1'b1;
                            next_state = S_CAP1;
                        end
                        else
                        begin
                            bus_wr     = 1'b1;
                            next_wdata = next_src_q;
                            next_done  = 1'b1;
                            next_busy  = 1'b0;
                        end
                    end
                    else if (mode_in == addr_mode_pkg::MODE_MEM_MOV)
                    begin
                        next_space_q = 1'b0;
                        bus_reg      = 1'b0;
                        bus_rd       = 1'b1;
                        next_addr    = opnd2_in;
                        next_state   = S_CAP1;
                    end
                    else if (mode_in != addr_mode_pkg::MODE_ILLEGAL)
                    begin
                        next_space_q = 1'b0;
                        bus_reg      = 1'b0;
                        bus_rd       = 1'b1;
                        next_addr    = opnd1_in;
                        next_state   = S_CAP1;
                    end
                    else
                    begin
                        // Unknown modes finish at once with no access
                        next_done = 1'b1;
                        next_busy = 1'b0;
                    end
                end
            end
            S_CAP1:
            begin
                unique case (mode_q)
                    addr_mode_pkg::MODE_MEM_MOV:
                    begin
                        bus_wr     = 1'b1;
                        next_addr  = op1_q;
                        next_wdata = rdata_in;
                        next_done  = 1'b1;
                        next_busy  = 1'b0;
                        next_state = S_IDLE;
                    end
                    addr_mode_pkg::MODE_SRC_IND:
                    begin
                        next_ptr_q = rdata_in;
                        bus_rd     = 1'b1;
                        next_addr  = rdata_in;
                        next_state = S_CAP2;
                    end
                    addr_mode_pkg::MODE_DST_IND:
                    begin
                        next_ptr_q = rdata_in;
                        bus_wr     = 1'b1;
                        next_addr  = rdata_in;
                        next_wdata = src_q;
                        next_state = S_INC;
                    end
                    default:
                    begin
                        // ALU sees both sources one cycle before the write
                        next_alu_a = src_q;
                        next_alu_b = rdata_in;
                        next_state = S_WR;
                    end
                endcase
            end
            S_WR:
            begin
                bus_wr     = 1'b1;
                next_addr  = ea_q;
                next_wdata = alu_result_in;
                next_done  = 1'b1;
                next_busy  = 1'b0;
                next_state = S_IDLE;
            end
            S_CAP2:
            begin
                next_acc_load = 1'b1;
                next_acc_data = rdata_in;
                bus_wr        = 1'b1;
                next_addr     = op1_q;
                next_wdata    = ptr_inc;
                next_done     = 1'b1;
                next_busy     = 1'b0;
                next_state    = S_IDLE;
            end
            S_INC:
            begin
                bus_wr     = 1'b1;
                next_addr  = op1_q;
                next_wdata = ptr_inc;
                next_done  = 1'b1;
                next_busy  = 1'b0;
                next_state = S_IDLE;
            end
            default:
            begin
                next_state = S_IDLE;
                next_busy  = 1'b0;
            end
        endcase
        next_ram_rd = bus_rd & ~bus_reg;
        next_ram_wr = bus_wr & ~bus_reg;
        next_reg_rd = bus_rd & bus_reg;
        next_reg_wr = bus_wr & bus_reg;
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            state        <= S_IDLE;
            mode_q       <= addr_mode_pkg::MODE_DST_DIR;
            arith_q      <= 1'b0;
            space_q      <= 1'b0;
            src_q        <= addr_mode_pkg::ZERO_BYTE;
            ea_q         <= addr_mode_pkg::ZERO_BYTE;
            op1_q        <= addr_mode_pkg::ZERO_BYTE;
            ptr_q        <= addr_mode_pkg::ZERO_BYTE;
            len_out      <= addr_mode_pkg::LEN_NONE;
            busy_out     <= 1'b0;
            done_out     <= 1'b0;
            addr_out     <= addr_mode_pkg::ZERO_BYTE;
            wdata_out    <= addr_mode_pkg::ZERO_BYTE;
            ram_rd_out   <= 1'b0;
            ram_wr_out   <= 1'b0;
            reg_rd_out   <= 1'b0;
            reg_wr_out   <= 1'b0;
            alu_a_out    <= addr_mode_pkg::ZERO_BYTE;
            alu_b_out    <= addr_mode_pkg::ZERO_BYTE;
            acc_load_out <= 1'b0;
            acc_data_out <= addr_mode_pkg::ZERO_BYTE;
        end
        else
        begin
            state        <= next_state;
            mode_q       <= next_mode_q;
            arith_q      <= next_arith_q;
            space_q      <= next_space_q;
            src_q        <= next_src_q;
            ea_q         <= next_ea_q;
            op1_q        <= next_op1_q;
            ptr_q        <= next_ptr_q;
            len_out      <= next_len;
            busy_out     <= next_busy;
            done_out     <= next_done;
            addr_out     <= next_addr;
            wdata_out    <= next_wdata;
            ram_rd_out   <= next_ram_rd;
            ram_wr_out   <= next_ram_wr;
            reg_rd_out   <= next_reg_rd;
            reg_wr_out   <= next_reg_wr;
            alu_a_out    <= next_alu_a;
            alu_b_out    <= next_alu_b;
            acc_load_out <= next_acc_load;
            acc_data_out <= next_acc_data;
        end
    end

    logic       go;
    logic [7:0] chk_sum;
    assign go      = start_in && state == S_IDLE;
    assign chk_sum = 8'(opnd1_in + idx_in);

    a_len_direct: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        go && (mode_in == addr_mode_pkg::MODE_DST_DIR || mode_in == addr_mode_pkg::MODE_DST_IDX)
        |=> len_out == addr_mode_pkg::LEN_TWO) else $error("direct length wrong");
    a_len_immediate: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        go && (mode_in == addr_mode_pkg::MODE_DST_DIR_IMM
            || mode_in == addr_mode_pkg::MODE_DST_IDX_IMM)
        |=> len_out == addr_mode_pkg::LEN_THREE) else $error("immediate length wrong");
    a_len_indirect: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        go && (mode_in == addr_mode_pkg::MODE_SRC_IND || mode_in == addr_mode_pkg::MODE_DST_IND)
        |=> len_out == addr_mode_pkg::LEN_TWO) else $error("indirect length wrong");
    a_direct_addr: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        go && mode_in == addr_mode_pkg::MODE_DST_DIR && !arith_in
        |=> (ram_wr_out || reg_wr_out) && addr_out == $past(opnd1_in) && done_out)
        else $error("direct write address wrong");
    a_space_select: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        go && mode_in == addr_mode_pkg::MODE_DST_DIR && !arith_in
        |=> reg_wr_out == $past(reg_space_in) && ram_wr_out == !$past(reg_space_in))
        else $error("space select wrong");
    a_indexed_acc: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        go && mode_in == addr_mode_pkg::MODE_DST_IDX && !arith_in
        |=> addr_out == $past(chk_sum) && wdata_out == $past(acc_in))
        else $error("indexed address or source wrong");
    a_idx_immediate: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        go && mode_in == addr_mode_pkg::MODE_DST_IDX_IMM && !arith_in
        |=> addr_out == $past(chk_sum) && wdata_out == $past(opnd2_in))
        else $error("indexed immediate wrong");
    a_arith_read: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        go && mode_in <= addr_mode_pkg::MODE_DST_IDX_IMM && arith_in
        |=> (ram_rd_out || reg_rd_out) ##1 1'b1 ##1 (ram_wr_out || reg_wr_out)
            && wdata_out == $past(alu_result_in)) else $error("arith sequence wrong");
    a_mem_move: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        go && mode_in == addr_mode_pkg::MODE_MEM_MOV
        |=> ram_rd_out && !reg_rd_out && addr_out == $past(opnd2_in)
        ##1 ram_wr_out && !reg_wr_out && wdata_out == $past(rdata_in) && done_out)
        else $error("memory move wrong");
    a_src_indirect: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        go && mode_in == addr_mode_pkg::MODE_SRC_IND
        |=> ram_rd_out ##1 ram_rd_out && addr_out == $past(rdata_in)
        ##1 acc_load_out && ram_wr_out && wdata_out == 8'($past(addr_out) + 8'h01))
        else $error("source indirect wrong");
    a_dst_indirect: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        go && mode_in == addr_mode_pkg::MODE_DST_IND
        |=> ram_rd_out ##1 ram_wr_out && wdata_out == $past(acc_in, 2)
        ##1 ram_wr_out && done_out && wdata_out == 8'($past(addr_out) + 8'h01))
        else $error("destination indirect wrong");
endmodule : cpu_operand_addressing

// ### dv/test_cpu_operand_addressing.sv
// Self-checking bench for the operand addressing sequencer
`timescale 1ns/1ps
module test_cpu_operand_addressing;
    logic                 clk_in;
    logic                 rst_n_in;
    logic                 start_in;
    addr_mode_pkg::mode_t mode_in;
    logic                 arith_in;
    logic                 src_x_in;
    logic                 reg_space_in;
    logic [7:0]           opnd1_in;
    logic [7:0]           opnd2_in;
    logic [7:0]           acc_in;
    logic [7:0]           idx_in;
    logic [7:0]           alu_result_in;
    logic [7:0]           rdata_in;
    logic [1:0]           len_out;
    logic                 busy_out;
    logic                 done_out;
    logic [7:0]           addr_out;
    logic [7:0]           wdata_out;
    logic                 ram_rd_out;
    logic                 ram_wr_out;
    logic                 reg_rd_out;
    logic                 reg_wr_out;
    logic [7:0]           alu_a_out;
    logic [7:0]           alu_b_out;
    logic                 acc_load_out;
    logic [7:0]           acc_data_out;
    logic [7:0]           ram [256];
    logic [7:0]           regs [256];
    logic [7:0]           acc_got;
    int                   miscompares;
    int                   check_count;
    int                   cyc;
    int                   nram;
    int                   nreg;
    int                   nacc;

    cpu_operand_addressing i_dut (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .start_in(start_in), .mode_in(mode_in),
        .arith_in(arith_in), .src_x_in(src_x_in), .reg_space_in(reg_space_in),
        .opnd1_in(opnd1_in), .opnd2_in(opnd2_in), .acc_in(acc_in), .idx_in(idx_in),
        .alu_result_in(alu_result_in), .rdata_in(rdata_in), .len_out(len_out),
        .busy_out(busy_out), .done_out(done_out), .addr_out(addr_out), .wdata_out(wdata_out),
        .ram_rd_out(ram_rd_out), .ram_wr_out(ram_wr_out), .reg_rd_out(reg_rd_out),
        .reg_wr_out(reg_wr_out), .alu_a_out(alu_a_out), .alu_b_out(alu_b_out),
        .acc_load_out(acc_load_out), .acc_data_out(acc_data_out)
    );

    // Bench ALU adds; unread bus shows a changing pattern so stale data cannot pass
    assign alu_result_in = 8'(alu_a_out + alu_b_out);
    assign rdata_in = ram_rd_out ? ram[addr_out] : (reg_rd_out ? regs[addr_out] : cyc[7:0]);

    always @(posedge clk_in)
    begin
        cyc++;
        if (ram_wr_out === 1'b1)
        begin
            ram[addr_out] = wdata_out;
            nram++;
        end
        if (reg_wr_out === 1'b1)
        begin
            regs[addr_out] = wdata_out;
            nreg++;
        end
        if (acc_load_out === 1'b1)
        begin
            acc_got = acc_data_out;
            nacc++;
        end
        if (cyc == 3000)
        begin
            miscompares++;
            report_and_stop();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // One instruction: start pulse, bounded wait for done, latency and length checked
    task automatic run(input addr_mode_pkg::mode_t m, input logic ar, input logic sx,
                       input logic rs, input logic [7:0] o1, input logic [7:0] o2,
                       input logic [7:0] a, input logic [7:0] x, input int lat,
                       input logic [1:0] len);
        int n;
        nram = 0;
        nreg = 0;
        nacc = 0;
        @(posedge clk_in);
        start_in <= 1'b1;
        mode_in <= m;
        arith_in <= ar;
        src_x_in <= sx;
        reg_space_in <= rs;
        opnd1_in <= o1;
        opnd2_in <= o2;
        acc_in <= a;
        idx_in <= x;
        @(posedge clk_in);
        start_in <= 1'b0;
        n = 0;
        // First look just after the taking edge: done of a one-cycle mode stands only then
        do
        begin
            if (n > 0)
                @(posedge clk_in);
            #1;
            n++;
            if (n == 1 && lat > 1)
                chk({7'h00, busy_out}, 8'h01, "busy while running");
        end while (done_out !== 1'b1 && n < 20);
        chk(n[7:0], lat[7:0], "latency to done");
        chk({6'h00, len_out}, {6'h00, len}, "instruction length");
        @(posedge clk_in);
        #1;
        chk({7'h00, busy_out}, 8'h00, "busy after done");
    endtask : run

    task automatic t_reset;
        #1;
        chk({6'h00, len_out}, 8'h00, "len after reset");
        chk({6'h00, busy_out, done_out}, 8'h00, "busy done after reset");
        chk({4'h0, ram_wr_out, reg_wr_out, ram_rd_out, acc_load_out}, 8'h00, "strobes");
        $display("test reset finished");
    endtask : t_reset

    task automatic t_direct;
        run(addr_mode_pkg::MODE_DST_DIR, 0, 0, 0, 8'h10, 8'h00, 8'h3C, 8'h77, 1, 2);
        chk(ram[8'h10], 8'h3C, "direct store A");
        chk(nreg[7:0], 8'h00, "no register write");
        run(addr_mode_pkg::MODE_DST_DIR, 0, 1, 1, 8'h08, 8'h00, 8'h3C, 8'h5A, 1, 2);
        chk(regs[8'h08], 8'h5A, "direct store X to reg");
        chk(nram[7:0], 8'h00, "no ram write");
        ram[8'h20] = 8'h11;
        run(addr_mode_pkg::MODE_DST_DIR, 1, 0, 0, 8'h20, 8'h00, 8'h22, 8'h00, 3, 2);
        chk(alu_a_out, 8'h22, "alu source");
        chk(alu_b_out, 8'h11, "alu destination");
        chk(ram[8'h20], 8'h33, "direct arith result");
        $display("test direct finished");
    endtask : t_direct

    task automatic t_indexed;
        // Operand F0 plus X 20 must wrap to 10
        ram[8'h10] = 8'h05;
        run(addr_mode_pkg::MODE_DST_IDX, 1, 1, 0, 8'hF0, 8'h00, 8'h03, 8'h20, 3, 2);
        chk(ram[8'h10], 8'h08, "indexed arith wraps");
        chk(alu_a_out, 8'h03, "indexed source is A");
        run(addr_mode_pkg::MODE_DST_IDX, 0, 1, 1, 8'h04, 8'h00, 8'h6E, 8'h02, 1, 2);
        chk(regs[8'h06], 8'h6E, "indexed reg store");
        chk(nram[7:0], 8'h00, "no ram write");
        $display("test indexed finished");
    endtask : t_indexed

    task automatic t_immediate;
        ram[8'h30] = 8'h01;
        run(addr_mode_pkg::MODE_DST_DIR_IMM, 1, 0, 0, 8'h30, 8'h41, 8'h99, 8'h00, 3, 3);
        chk(ram[8'h30], 8'h42, "direct imm arith");
        chk(alu_a_out, 8'h41, "imm is source");
        run(addr_mode_pkg::MODE_DST_IDX_IMM, 0, 0, 1, 8'hFF, 8'hC3, 8'h99, 8'h02, 1, 3);
        chk(regs[8'h01], 8'hC3, "indexed imm wraps");
        regs[8'h40] = 8'h10;
        run(addr_mode_pkg::MODE_DST_DIR_IMM, 1, 0, 1, 8'h40, 8'h05, 8'h99, 8'h00, 3, 3);
        chk(regs[8'h40], 8'h15, "reg space imm arith");
        chk(nram[7:0], 8'h00, "reg arith stays in reg space");
        $display("test immediate finished");
    endtask : t_immediate

    task automatic t_move;
        ram[8'h50] = 8'h9C;
        run(addr_mode_pkg::MODE_MEM_MOV, 1, 0, 1, 8'h60, 8'h50, 8'h00, 8'h00, 2, 3);
        chk(ram[8'h60], 8'h9C, "move copies");
        chk(ram[8'h50], 8'h9C, "source kept");
        chk(nreg[7:0], 8'h00, "move stays in ram");
        $display("test move finished");
    endtask : t_move

    task automatic t_indirect;
        ram[8'h70] = 8'hFF;
        ram[8'hFF] = 8'hE7;
        run(addr_mode_pkg::MODE_SRC_IND, 0, 0, 1, 8'h70, 8'h00, 8'h00, 8'h00, 3, 2);
        chk(acc_got, 8'hE7, "indirect load");
        chk(nacc[7:0], 8'h01, "one acc load");
        chk(ram[8'h70], 8'h00, "pointer wraps");
        ram[8'h71] = 8'h80;
        run(addr_mode_pkg::MODE_DST_IND, 0, 0, 1, 8'h71, 8'h00, 8'h4D, 8'h00, 3, 2);
        chk(ram[8'h80], 8'h4D, "indirect store");
        chk(ram[8'h71], 8'h81, "pointer incremented");
        chk(nreg[7:0], 8'h00, "indirect stays in ram");
        $display("test indirect finished");
    endtask : t_indirect

    task automatic t_illegal;
        run(addr_mode_pkg::MODE_ILLEGAL, 1, 0, 0, 8'h10, 8'h00, 8'h00, 8'h00, 1, 0);
        chk(nram[7:0] | nreg[7:0], 8'h00, "illegal has no access");
        $display("test illegal finished");
    endtask : t_illegal

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : report_and_stop

    initial
    begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end

    initial
    begin
        rst_n_in = 1'b0;
        start_in = 1'b0;
        mode_in = addr_mode_pkg::MODE_DST_DIR;
        arith_in = 1'b0;
        src_x_in = 1'b0;
        reg_space_in = 1'b0;
        opnd1_in = 8'h00;
        opnd2_in = 8'h00;
        acc_in = 8'h00;
        idx_in = 8'h00;
        acc_got = 8'h00;
        miscompares = 0;
        check_count = 0;
        cyc = 0;
        for (int i = 0; i < 256; i++)
        begin
            ram[i] = 8'h00;
            regs[i] = 8'h00;
        end
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'b1;
        t_reset();
        t_direct();
        t_indexed();
        t_immediate();
        t_move();
        t_indirect();
        t_illegal();
        report_and_stop();
    end
endmodule : test_cpu_operand_addressing
